// ---- design/timed_io_port_defines.vh ----
// Constants for the timed I/O port: register offsets, field positions, reset values, timing counts.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef TIMED_IO_PORT_DEFINES_VH
`define TIMED_IO_PORT_DEFINES_VH

// Timing
`define CORE_CLK_MHZ      200
`define REF_CLK_MHZ       100
`define REF_DIV_CYCLES    (`CORE_CLK_MHZ / `REF_CLK_MHZ)
`define NUM_CLK_BLOCKS    6

// Register byte offsets
`define OFS_CTRL          8'h00
`define OFS_DATA          8'h04
`define OFS_COND          8'h08
`define OFS_TIME          8'h0C
`define OFS_COUNT         8'h10
`define OFS_STAMP         8'h14
`define OFS_STATUS        8'h18
`define OFS_IRQ_STAT      8'h1C
`define OFS_IRQ_MASK      8'h20
`define OFS_CLKDIV1       8'h24
`define OFS_CLKDIV_LAST   8'h34

// Control field positions
`define CTRL_ENABLE       0
`define CTRL_DIR_OUT      1
`define CTRL_OPEN_DRAIN   2
`define CTRL_SERIALIZE    3
`define CTRL_TIMED        4
`define CTRL_STROBE_EN    5
`define CTRL_COND_LSB     6
`define CTRL_COND_MSB     7
`define CTRL_CLKSEL_LSB   8
`define CTRL_CLKSEL_MSB   10
`define CTRL_WIDTH        11

// Wait conditions
`define COND_NONE         2'h0
`define COND_EQ           2'h1
`define COND_NEQ          2'h2

// Clock divider fields
`define CLKDIV_DIV_MSB    15
`define CLKDIV_EXT_SRC    16
`define CLKDIV_WIDTH      17

// Status and interrupt bits
`define STAT_OUT_BUSY     0
`define STAT_IN_VALID     1
`define IRQ_OUT_DONE      0
`define IRQ_IN_READY      1
`define IRQ_COND_MET      2
`define IRQ_BITS          3

// Reset values
`define CTRL_RESET        11'h000
`define CLKDIV_RESET      17'h00000
`define IRQ_MASK_RESET    3'h0

`endif

// ---- design/timed_io_port.v ----
// One timed I/O port with its six clock blocks, reached over an AHB-Lite slave.
// Assumes pins arrive asynchronously; link enable and shared-pin claims come from logic on core_clk.
//
// Overview of operation
// - The port has a fixed width of 1, 4, 8, 16 or 32 bits and all its pins go one way at a time.
// - The port drives its pins high or low, or samples them, optionally waiting for a pin condition.
// - Every register access by the core completes with no wait state.
// - In open-drain mode a zero pulls the pin low and a one leaves it undriven, selectable per port.
// - Data passes through a serializer/deserializer and a transfer register.
// - A 16-bit port counter is readable at any time and can delay a transfer until a given count.
// - Each transfer captures the counter value as a timestamp for later reading.
// - An enabled link on the same pins disables the port's pins.
// - A narrower port claiming shared pins wins over this port; unshared pins stay usable.
// - The port keeps its own width even when some pins are claimed elsewhere.
// - Six clock blocks exist; block 0 is the 100 MHz reference, the rest are programmable.
// - A clock block may take a 1-bit pin as its source, optionally divided.
// - An incoming strobe qualifies input data and an outgoing strobe accompanies output data.
// - After reset the port is attached to clock block 0.
// - Pin events go straight to the event scheduler as a pulse, not through the interrupt.
`timescale 1ns/1ps
`include "timed_io_port_defines.vh"

module timed_io_port #(
  parameter WIDTH = 8
) (
  input  wire              core_clk,
  input  wire              rstn,
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire [31:0]       hrdata,
  output wire              hreadyout,
  output wire              hresp,
  input  wire [WIDTH-1:0]  pin_i,
  output wire [WIDTH-1:0]  pin_o,
  output wire [WIDTH-1:0]  pin_oe_n,
  input  wire              strobe_in,
  output wire              outgoing_strobe_qualifier,
  input  wire              ext_clk_pin,
  input  wire              link_enable,
  input  wire [WIDTH-1:0]  narrow_claim,
  output wire              sched_event,
  output wire              irq
);

  localparam CHUNKS = 32 / WIDTH;

  // Synchronisers for pins, strobe and external clock
  reg  [WIDTH-1:0]       pin_m_q;
  reg  [WIDTH-1:0]       pin_s_q;
  reg                    stb_m_q;
  reg                    stb_s_q;
  reg                    eclk_m_q;
  reg                    eclk_s_q;
  reg                    eclk_d_q;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_m_q <= {WIDTH{1'b0}};
      pin_s_q <= {WIDTH{1'b0}};
    end else begin
      pin_m_q <= pin_i;
      pin_s_q <= pin_m_q;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stb_m_q <= 1'b0;
      stb_s_q <= 1'b0;
    end else begin
      stb_m_q <= strobe_in;
      stb_s_q <= stb_m_q;
    end
  end

  // Edge detector resets low, the idle level of the clock pin, so no false edge follows reset
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      eclk_m_q <= 1'b0;
      eclk_s_q <= 1'b0;
      eclk_d_q <= 1'b0;
    end else begin
      eclk_m_q <= ext_clk_pin;
      eclk_s_q <= eclk_m_q;
      eclk_d_q <= eclk_s_q;
    end
  end

  wire eclk_rise = eclk_s_q & ~eclk_d_q;

  // Registers
  reg  [`CTRL_WIDTH-1:0]   ctrl_q;
  reg  [31:0]              cond_q;
  reg  [15:0]              time_q;
  reg  [15:0]              count_q;
  reg  [15:0]              stamp_q;
  reg  [`IRQ_BITS-1:0]     irq_stat_q;
  reg  [`IRQ_BITS-1:0]     irq_mask_q;
  reg  [`CLKDIV_WIDTH-1:0] clkdiv_q [1:`NUM_CLK_BLOCKS-1];

  wire       en        = ctrl_q[`CTRL_ENABLE];
  wire       dir_out   = ctrl_q[`CTRL_DIR_OUT];
  wire       od        = ctrl_q[`CTRL_OPEN_DRAIN];
  wire       ser       = ctrl_q[`CTRL_SERIALIZE];
  wire       timed     = ctrl_q[`CTRL_TIMED];
  wire       stb_en    = ctrl_q[`CTRL_STROBE_EN];
  wire [1:0] cond_mode = ctrl_q[`CTRL_COND_MSB:`CTRL_COND_LSB];
  wire [2:0] clk_sel   = ctrl_q[`CTRL_CLKSEL_MSB:`CTRL_CLKSEL_LSB];

  // Clock blocks: one-cycle tick enables
  wire [`NUM_CLK_BLOCKS-1:0] cb_tick;
  reg  [7:0]                 ref_cnt_q;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ref_cnt_q <= 8'h00;
    end else if (ref_cnt_q == (`REF_DIV_CYCLES - 1)) begin
      ref_cnt_q <= 8'h00;
    end else begin
      ref_cnt_q <= ref_cnt_q + 8'h01;
    end
  end

  assign cb_tick[0] = (ref_cnt_q == (`REF_DIV_CYCLES - 1));

  genvar gi;
  generate
    for (gi = 1; gi < `NUM_CLK_BLOCKS; gi = gi + 1) begin : g_cb
      reg  [15:0] div_cnt_q;
      wire        src_edge = clkdiv_q[gi][`CLKDIV_EXT_SRC] ? eclk_rise : 1'b1;
      wire        wrap     = (div_cnt_q == clkdiv_q[gi][`CLKDIV_DIV_MSB:0]);
      always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          div_cnt_q <= 16'h0000;
        end else if (src_edge) begin
          div_cnt_q <= wrap ? 16'h0000 : div_cnt_q + 16'h0001;
        end
      end
      assign cb_tick[gi] = src_edge & wrap;
    end
  endgenerate

  // Attached clock block; unused selector codes fall back to the reference
  reg tick;
  always @* begin
    tick = cb_tick[0];
    case (clk_sel)
      3'h1:    tick = cb_tick[1];
      3'h2:    tick = cb_tick[2];
      3'h3:    tick = cb_tick[3];
      3'h4:    tick = cb_tick[4];
      3'h5:    tick = cb_tick[5];
      default: tick = cb_tick[0];
    endcase
  end

  // Bus address phase
  reg        wr_q;
  reg  [7:0] addr_q;
  reg [31:0] rdata_q;
  wire       take = hsel & htrans[1] & hready;

  // Transfer engine state
  reg  [31:0]      xfer_q;
  reg  [5:0]       left_q;
  reg              busy_q;
  reg              in_valid_q;
  reg  [WIDTH-1:0] drive_q;
  reg              ostb_q;

  wire [WIDTH+31:0] in_cat   = {pin_s_q, xfer_q};
  wire [WIDTH+31:0] pin_wide = {32'h0000_0000, pin_s_q};
  wire              first    = (left_q == 6'h00);
  wire              time_ok  = ~timed | ~first | (count_q == time_q);
  wire              pin_eq   = (pin_s_q == cond_q[WIDTH-1:0]);
  reg               cond_ok;

  // Unused condition code 3 never blocks sampling
  always @* begin
    cond_ok = 1'b1;
    case (cond_mode)
      `COND_NONE: begin
        cond_ok = 1'b1;
      end
      `COND_EQ: begin
        cond_ok = pin_eq;
      end
      `COND_NEQ: begin
        cond_ok = ~pin_eq;
      end
      default: begin
        cond_ok = 1'b1;
      end
    endcase
  end

  wire [5:0]        n_chunks = ser ? CHUNKS[5:0] : 6'h01;

  wire out_step = en & dir_out & busy_q & tick & time_ok;
  wire out_last = out_step & ((left_q + 6'h01) == n_chunks);
  wire in_step  = en & ~dir_out & ~in_valid_q & tick & time_ok & (~stb_en | stb_s_q)
                  & (~first | cond_ok);
  wire in_last  = in_step & ((left_q + 6'h01) == n_chunks);

  wire data_wr = wr_q & (addr_q == `OFS_DATA);
  wire data_rd = take & ~hwrite & (haddr[7:0] == `OFS_DATA);

  // Counter runs even while the port is disabled so software always sees time move
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= 16'h0000;
    end else if (tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Strobe stands for one whole tick period of the attached block
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ostb_q <= 1'b0;
    end else if (tick) begin
      ostb_q <= out_step;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      xfer_q     <= 32'h0000_0000;
      left_q     <= 6'h00;
      busy_q     <= 1'b0;
      in_valid_q <= 1'b0;
      drive_q    <= {WIDTH{1'b0}};
      stamp_q    <= 16'h0000;
    end else begin
      if (data_wr & dir_out & ~busy_q) begin
        xfer_q <= hwdata;
        busy_q <= 1'b1;
        left_q <= 6'h00;
      end else if (out_step) begin
        drive_q <= xfer_q[WIDTH-1:0];
        xfer_q  <= xfer_q >> WIDTH;
        left_q  <= out_last ? 6'h00 : left_q + 6'h01;
        if (out_last) begin
          busy_q  <= 1'b0;
          stamp_q <= count_q;
        end
      end else if (in_step) begin
        xfer_q <= ser ? in_cat[WIDTH+31:WIDTH] : pin_wide[31:0];
        left_q <= in_last ? 6'h00 : left_q + 6'h01;
        if (in_last) begin
          in_valid_q <= 1'b1;
          stamp_q    <= count_q;
        end
      end
      // Reading the transfer register frees it; a word landing this same cycle still wins
      if (data_rd & ~in_last) begin
        in_valid_q <= 1'b0;
      end
      if (~en | (wr_q & (addr_q == `OFS_CTRL))) begin
        left_q <= 6'h00;
      end
    end
  end

  // Pin drivers: link wins, then narrower ports, then this port's own mode
  genvar pi;
  generate
    for (pi = 0; pi < WIDTH; pi = pi + 1) begin : g_pin
      wire owned = en & dir_out & ~link_enable & ~narrow_claim[pi];
      assign pin_o[pi]    = od ? 1'b0 : drive_q[pi];
      assign pin_oe_n[pi] = ~(owned & (~od | ~drive_q[pi]));
    end
  endgenerate

  assign outgoing_strobe_qualifier = ostb_q & en & dir_out & ~link_enable;

  // Scheduler events: one-cycle pulse per finished transfer or met condition
  wire cond_hit = in_step & first & (cond_mode != `COND_NONE);
  assign sched_event = out_last | in_last | cond_hit;

  // Bus slave; zero wait states so every access is done in one cycle
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  wire [`IRQ_BITS-1:0] irq_set = {cond_hit, in_last, out_last};
  wire [`IRQ_BITS-1:0] irq_clr = (wr_q & (addr_q == `OFS_IRQ_STAT)) ? hwdata[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};
  wire                 div_hit = (haddr[7:0] >= `OFS_CLKDIV1) & (haddr[7:0] <= `OFS_CLKDIV_LAST);
  wire [2:0]           div_idx = haddr[4:2] - 3'h1;
  wire [2:0]           wdiv_idx = addr_q[4:2] - 3'h1;
  wire                 wdiv_hit = (addr_q >= `OFS_CLKDIV1) & (addr_q <= `OFS_CLKDIV_LAST);

  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case (haddr[7:0])
      `OFS_CTRL:     rd_d = {21'h000000, ctrl_q};
      `OFS_DATA:     rd_d = xfer_q;
      `OFS_COND:     rd_d = cond_q;
      `OFS_TIME:     rd_d = {16'h0000, time_q};
      `OFS_COUNT:    rd_d = {16'h0000, count_q};
      `OFS_STAMP:    rd_d = {16'h0000, stamp_q};
      `OFS_STATUS:   rd_d = {30'h00000000, in_valid_q, busy_q};
      `OFS_IRQ_STAT: rd_d = {29'h00000000, irq_stat_q};
      `OFS_IRQ_MASK: rd_d = {29'h00000000, irq_mask_q};
      default: begin
        if (div_hit) begin
          rd_d = {15'h0000, clkdiv_q[div_idx + 3'h1]};
        end
      end
    endcase
  end

  // Address phase is registered; the data phase write lands at the end of the next cycle
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_q    <= 1'b0;
      addr_q  <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_q   <= take & hwrite;
      addr_q <= haddr[7:0];
      if (take & ~hwrite) begin
        rdata_q <= rd_d;
      end
    end
  end

  // Set wins over a simultaneous write-one clear
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_q <= {`IRQ_BITS{1'b0}};
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q     <= `CTRL_RESET;
      cond_q     <= 32'h0000_0000;
      time_q     <= 16'h0000;
      irq_mask_q <= `IRQ_MASK_RESET;
    end else if (wr_q) begin
      case (addr_q)
        `OFS_CTRL:     ctrl_q     <= hwdata[`CTRL_WIDTH-1:0];
        `OFS_COND:     cond_q     <= hwdata;
        `OFS_TIME:     time_q     <= hwdata[15:0];
        `OFS_IRQ_MASK: irq_mask_q <= hwdata[`IRQ_BITS-1:0];
        default: begin
        end
      endcase
    end
  end

  integer k;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (k = 1; k < `NUM_CLK_BLOCKS; k = k + 1) begin
        clkdiv_q[k] <= `CLKDIV_RESET;
      end
    end else if (wr_q & wdiv_hit) begin
      clkdiv_q[wdiv_idx + 3'h1] <= hwdata[`CLKDIV_WIDTH-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

endmodule // timed_io_port

// ---- bench/timed_io_port_chk.sv ----
// Checker for the timed I/O port, bound to every instance.
// Assumes one core_clk domain with active-low rstn.
`timescale 1ns/1ps
module timed_io_port_chk #(
  parameter WIDTH = 8
) (
  input wire             core_clk,
  input wire             rstn,
  input wire             hreadyout,
  input wire             hresp,
  input wire [WIDTH-1:0] pin_oe_n,
  input wire             link_enable,
  input wire [WIDTH-1:0] narrow_claim,
  input wire             sched_event,
  input wire             outgoing_strobe_qualifier,
  input wire             irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_no_wait: assert property (hreadyout)
    else $error("wait state");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_link_release: assert property (link_enable |-> &pin_oe_n)
    else $error("pin driven under link");
  a_claim_release: assert property ((pin_oe_n & narrow_claim) == narrow_claim)
    else $error("claimed pin driven");
  a_event_pulse: assert property (sched_event |=> !sched_event)
    else $error("event too long");
  // Block 0 ticks every second cycle, so one tick period is two cycles
  a_strobe_len: assert property ($rose(outgoing_strobe_qualifier) |-> outgoing_strobe_qualifier[*2])
    else $error("strobe too short");
  a_strobe_event: assert property ($rose(outgoing_strobe_qualifier) |-> $past(sched_event) || !(&pin_oe_n))
    else $error("strobe without event");
  a_reset_idle: assert property ($rose(rstn) |-> &pin_oe_n && !irq && !sched_event)
    else $error("not idle after reset");
endmodule // timed_io_port_chk

bind timed_io_port timed_io_port_chk #(.WIDTH(WIDTH)) i_chk (
  .core_clk(core_clk), .rstn(rstn), .hreadyout(hreadyout), .hresp(hresp),
  .pin_oe_n(pin_oe_n), .link_enable(link_enable), .narrow_claim(narrow_claim),
  .sched_event(sched_event), .outgoing_strobe_qualifier(outgoing_strobe_qualifier), .irq(irq));

// ---- bench/pin_partner.sv ----
// External hardware on the port pins: data source, strobe and application clock.
// Assumes the bench steers it on core_clk; lines change just after a rising edge.
`timescale 1ns/1ps
module pin_partner #(
  parameter WIDTH = 8
) (
  input  wire             core_clk,
  input  wire             drive,
  input  wire [WIDTH-1:0] value,
  input  wire             stb,
  input  wire             clk_run,
  output reg  [WIDTH-1:0] pins,
  output reg              strobe_in,
  output reg              ext_clk_pin
);
  reg [1:0] div_q;
  initial begin
    pins = {WIDTH{1'h0}};
    strobe_in = 1'h0;
    ext_clk_pin = 1'h0;
    div_q = 2'h0;
  end
  always @(posedge core_clk) begin
    // Released lines keep moving so a stale value never passes for data
    pins <= drive ? value : ~pins;
    strobe_in <= stb;
    // Clock stands low outside bursts, toggles every third cycle to suit the synchroniser
    div_q <= (clk_run && div_q != 2'h2) ? div_q + 2'h1 : 2'h0;
    ext_clk_pin <= clk_run ? (ext_clk_pin ^ (div_q == 2'h2)) : 1'h0;
  end
endmodule // pin_partner

// ---- bench/tb.sv ----
// Self-checking bench for the timed I/O port: an AHB-Lite master and one task per scenario.
// Assumes an 8-bit port, the pin partner model and the bound checker.
`timescale 1ns/1ps
`include "timed_io_port_defines.vh"
module tb;
  reg        core_clk = 1'h0;
  reg        rstn = 1'h0;
  reg [31:0] haddr = 32'h0;
  reg [1:0]  htrans = 2'h0;
  reg        hwrite = 1'h0;
  reg [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire       hreadyout, hresp, strobe_in, strobe_q, ext_clk_pin, sched_event, irq;
  wire [7:0] pin_i, pin_o, pin_oe_n, ext_pins;
  reg        link_enable = 1'h0;
  reg [7:0]  narrow_claim = 8'h00;
  reg        p_drive = 1'h0;
  reg [7:0]  p_value = 8'h00;
  reg        p_stb = 1'h0;
  reg        p_run = 1'h0;
  integer    bad_count = 0;
  integer    checks = 0;
  reg [31:0] c, d;
  always #2.5 core_clk = ~core_clk;
  // Whoever holds the enable sets the wire level
  assign pin_i = (pin_oe_n & ext_pins) | (~pin_oe_n & pin_o);
  timed_io_port #(.WIDTH(8)) i_timed_io_port (
    .core_clk(core_clk), .rstn(rstn), .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .strobe_in(strobe_in),
    .outgoing_strobe_qualifier(strobe_q), .ext_clk_pin(ext_clk_pin), .link_enable(link_enable),
    .narrow_claim(narrow_claim), .sched_event(sched_event), .irq(irq));
  pin_partner #(.WIDTH(8)) i_pin_partner (
    .core_clk(core_clk), .drive(p_drive), .value(p_value), .stb(p_stb), .clk_run(p_run),
    .pins(ext_pins), .strobe_in(strobe_in), .ext_clk_pin(ext_clk_pin));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] wd, output [31:0] rd);
    begin
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge core_clk);
      while (hreadyout !== 1'h1) @(posedge core_clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge core_clk);
      while (hreadyout !== 1'h1) @(posedge core_clk);
      rd = hrdata;
    end
  endtask
  task wait_for(input sel);
    integer n;
    begin
      n = 0;
      @(negedge core_clk);
      while ((sel ? irq : sched_event) !== 1'h1 && n < 400) begin
        @(negedge core_clk);
        n = n + 1;
      end
      chk(n < 400, 32'h1);
      // Back on a rising edge with the finished chunk settled on the pins
      repeat (2) @(posedge core_clk);
    end
  endtask
  task t_reset;
    begin
      bus(0, `OFS_CTRL, 32'h0, d);
      chk(d, 32'h0);
      bus(0, `OFS_IRQ_MASK, 32'h0, d);
      chk(d, 32'h0);
      bus(0, 8'h40, 32'h0, d);
      chk(d, 32'h0);
      chk(pin_oe_n, 8'hFF);
      bus(0, `OFS_COUNT, 32'h0, c);
      repeat (20) @(posedge core_clk);
      bus(0, `OFS_COUNT, 32'h0, d);
      chk((d - c) & 32'hFFFF, 32'hB);
    end
  endtask
  task t_out;
    begin
      bus(1, `OFS_CTRL, 32'h13, d);
      bus(0, `OFS_COUNT, 32'h0, c);
      bus(1, `OFS_TIME, (c + 32'h1E) & 32'hFFFF, d);
      bus(1, `OFS_DATA, 32'hA5, d);
      wait_for(0);
      chk(pin_o, 8'hA5);
      chk(pin_oe_n, 8'h00);
      bus(0, `OFS_STAMP, 32'h0, d);
      chk(d, (c + 32'h1E) & 32'hFFFF);
      bus(0, `OFS_STATUS, 32'h0, d);
      chk(d[0], 1'h0);
      chk(irq, 1'h0);
      bus(1, `OFS_IRQ_MASK, 32'h1, d);
      repeat (2) @(posedge core_clk);
      chk(irq, 1'h1);
      bus(1, `OFS_IRQ_STAT, 32'h1, d);
      repeat (2) @(posedge core_clk);
      chk(irq, 1'h0);
    end
  endtask
  task t_od;
    begin
      bus(1, `OFS_CTRL, 32'h07, d);
      bus(1, `OFS_DATA, 32'h0F, d);
      wait_for(0);
      chk(pin_o, 8'h00);
      chk(pin_oe_n, 8'h0F);
      narrow_claim <= 8'h30;
      repeat (2) @(posedge core_clk);
      chk(pin_oe_n, 8'h3F);
      link_enable <= 1'h1;
      repeat (2) @(posedge core_clk);
      chk(pin_oe_n, 8'hFF);
      link_enable <= 1'h0;
      narrow_claim <= 8'h00;
    end
  endtask
  task t_in;
    begin
      p_drive <= 1'h1;
      p_stb <= 1'h1;
      bus(1, `OFS_COND, 32'h5A, d);
      bus(1, `OFS_IRQ_STAT, 32'h7, d);
      bus(1, `OFS_IRQ_MASK, 32'h2, d);
      bus(1, `OFS_CTRL, 32'h69, d);
      repeat (20) @(posedge core_clk);
      bus(0, `OFS_STATUS, 32'h0, d);
      chk(d[1], 1'h0);
      p_value <= 8'h5A;
      wait_for(1);
      bus(0, `OFS_IRQ_STAT, 32'h0, d);
      chk(d[2:0], 3'h6);
      // Strobe held low must stop a fresh word from landing once the register frees
      p_stb <= 1'h0;
      repeat (4) @(posedge core_clk);
      bus(0, `OFS_DATA, 32'h0, d);
      chk(d, 32'h5A5A5A5A);
      repeat (20) @(posedge core_clk);
      bus(0, `OFS_STATUS, 32'h0, d);
      chk(d[1], 1'h0);
      p_drive <= 1'h0;
    end
  endtask
  task t_ext;
    begin
      bus(1, `OFS_CLKDIV1, 32'h10000, d);
      bus(1, `OFS_CTRL, 32'h100, d);
      repeat (10) @(posedge core_clk);
      bus(0, `OFS_COUNT, 32'h0, c);
      p_run <= 1'h1;
      repeat (60) @(posedge core_clk);
      p_run <= 1'h0;
      repeat (10) @(posedge core_clk);
      bus(0, `OFS_COUNT, 32'h0, d);
      chk((d - c) & 32'hFFFF, 32'hA);
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'h1;
    @(posedge core_clk);
    t_reset;
    t_out;
    t_od;
    t_in;
    t_ext;
    results;
  end
  // The tests need a few hundred cycles; twenty thousand means a hang
  initial begin
    #100000;
    bad_count = bad_count + 1;
    results;
  end
endmodule // tb
